// ---- verilog/iq_pkg.sv ----
// Purpose: Shared constants for the second interrupt bank status block.
// Assumes: Word index map; the byte address is four times the index.
// Notes:   Slot tables list raw words in ascending index order.
package iq_pkg;

    // ------------------------------------------------------------
    // Bus and word geometry
    // ------------------------------------------------------------
    localparam int IQ_DW = 32;
    localparam int IQ_AW = 16;
    localparam int IQ_RW = 16;
    localparam int IQ_NSLOT = 13;
    localparam int IQ_IDXW = 14;

    typedef logic [IQ_IDXW-1:0] iq_idx_t;
    typedef logic [IQ_RW-1:0] iq_word_t;
    typedef logic [3:0] iq_slot_t;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam iq_idx_t IQ_RAW_IDX [IQ_NSLOT] = '{
        14'h1981, 14'h1986, 14'h1988, 14'h198b, 14'h198c, 14'h198d, 14'h1990,
        14'h1995, 14'h1996, 14'h1997, 14'h1998, 14'h199d, 14'h19a3};
    localparam iq_word_t IQ_RAW_BITS [IQ_NSLOT] = '{
        16'h0160, 16'h0115, 16'h0307, 16'h033f, 16'h003f, 16'h003f, 16'hffff,
        16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h000f};
    localparam iq_idx_t IQ_FLAG_DELTA = 14'h0080;
    localparam iq_idx_t IQ_MASK_DELTA = 14'h0040;
    localparam iq_idx_t IQ_CTRL_IDX = 14'h1a80;
    localparam iq_idx_t IQ_SUMMARY_IDX = 14'h1aa0;
    localparam iq_slot_t IQ_NO_SLOT = 4'hf;

    // ------------------------------------------------------------
    // Slots and field positions
    // ------------------------------------------------------------
    localparam int IQ_S_CLOCK = 0;
    localparam int IQ_S_JACK = 1;
    localparam int IQ_S_CONV = 2;
    localparam int IQ_S_SHORT = 3;
    localparam int IQ_S_ON = 4;
    localparam int IQ_S_OFF = 5;
    localparam int IQ_S_PINS = 6;
    localparam int IQ_S_EVNE = 7;
    localparam int IQ_S_EVFULL = 8;
    localparam int IQ_S_EVLVL = 9;
    localparam int IQ_S_DMA = 10;
    localparam int IQ_S_BUSY = 11;
    localparam int IQ_S_ALARM = 12;
    localparam int IQ_LOOP_A_LOCK_POS = 8;
    localparam int IQ_LOOP_B_REF_POS = 6;
    localparam int IQ_LOOP_A_REF_POS = 5;
    localparam int IQ_JACK3_POS = 8;
    localparam int IQ_CLAMP_POS = 4;
    localparam int IQ_JACK2_POS = 2;
    localparam int IQ_JACK1_POS = 0;
    localparam int IQ_CONV_B_POS = 9;
    localparam int IQ_CONV_A_POS = 8;
    localparam int IQ_INPUT_DET_POS = 2;
    localparam int IQ_DRC_B_POS = 1;
    localparam int IQ_DRC_A_POS = 0;
    localparam int IQ_SHORT_HI_POS = 8;
    localparam int IQ_CTRL_MASK_POS = 11;
    localparam int IQ_CTRL_POL_POS = 10;
    localparam int IQ_CTRL_ODRAIN_POS = 9;
    localparam int IQ_SUM_BANK2_POS = 1;

    // ------------------------------------------------------------
    // Reset values and writable control bits
    // ------------------------------------------------------------
    localparam iq_word_t IQ_CTRL_RESET = 16'h0400;
    localparam iq_word_t IQ_CTRL_BITS = 16'h0e00;
    localparam iq_word_t IQ_MASK_RESET = 16'hffff;

    // Slot whose raw index minus delta matches idx
    function automatic iq_slot_t iq_slot_of(input iq_idx_t idx, input iq_idx_t delta);
        iq_slot_t s;
        s = IQ_NO_SLOT;
        for (int i = 0; i < IQ_NSLOT; i++)
        begin
            if (IQ_RAW_IDX[i] - delta == idx)
                s = 4'(i);
        end
        return s;
    endfunction : iq_slot_of

endpackage : iq_pkg

// ---- verilog/iq_sync.sv ----
// Purpose: Two-stage synchroniser for a bus of independent levels.
// Assumes: Each bit is a slow level; bits are not coherent with each other.
// Notes:   The first stage feeds only the second.
module iq_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // Refuse an empty bus
    if (W < 1)
    begin : g_bad_width
        $error("W must be at least 1");
    end

    // Two flip-flops in series
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : iq_sync

// ---- verilog/iq_flag_bank.sv ----
// Purpose: Latched event flags with write-one-to-clear and mask words.
// Assumes: set, clr and mask writes arrive on clk_sys.
// Notes:   A set in the clearing cycle keeps the flag.
module iq_flag_bank
    import iq_pkg::*;
#(
    parameter int NSLOT = iq_pkg::IQ_NSLOT
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [NSLOT*iq_pkg::IQ_RW-1:0] set_i,
    input wire logic [NSLOT*iq_pkg::IQ_RW-1:0] clr_i,
    input wire logic [NSLOT-1:0] mask_we_i,
    input wire logic [iq_pkg::IQ_RW-1:0] wdata_i,
    output logic [NSLOT*iq_pkg::IQ_RW-1:0] flags_o,
    output logic [NSLOT*iq_pkg::IQ_RW-1:0] masks_o,
    output logic pending_o
);
    // Flags: set by event, cleared by a one written
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            flags_o <= '0;
        else
            flags_o <= (flags_o & ~clr_i) | set_i;
    end

    // Masks: plain read/write words, masked at reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            masks_o <= {NSLOT{IQ_MASK_RESET}};
        else
            for (int s = 0; s < NSLOT; s++)
            begin
                if (mask_we_i[s])
                    masks_o[s*IQ_RW +: IQ_RW] <= wdata_i;
            end
    end

    // Bank summary
    assign pending_o = |(flags_o & ~masks_o);

    a_flag_sets_on_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (|set_i) |=> ((flags_o & $past(set_i)) == $past(set_i)))
        else $error("event did not latch its flag");
    a_flag_clear_only_w1c: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 (($past(flags_o) & ~flags_o & ~$past(clr_i)) == '0))
        else $error("flag fell without a clearing write");
    a_mask_reset_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(rst_b) |-> (masks_o == {NSLOT{IQ_MASK_RESET}}))
        else $error("mask words not all ones after reset");
endmodule : iq_flag_bank

// ---- verilog/iq_status_top.sv ----
// Purpose: Raw status, latched flags, masks and interrupt output of bank two.
// Assumes: APB slave, zero wait states; all condition inputs are asynchronous.
// Notes:   Word at index n sits at byte address 4*n; upper 16 data bits read 0.

// Summary of operation
// - Clock loop status: lock of loop A bit 8, reference lost B bit 6, A bit 5.
// - Jack present bits 8, 2, 0 read 1 when the sense pin is low.
// - One clamp bit at position 4 reads 1 when any clamp is enabled.
// - A clamp enabled only by its override does not show in the clamp bit.
// - Converter input B and A lock at bits 9 and 8, live.
// - Signal detect: input path bit 2, range controllers B bit 1, A bit 0.
// - One short-circuit bit per phones channel at bits 9, 8 and 5 to 0.
// - Enable-done bits read 0 while sequencing, 1 once done.
// - Disable-done bits 5 to 0 read 0 while sequencing, 1 once done.
// - Pin level word holds live levels of pins sixteen down to one.
// - Pin level is meaningful only for plain inputs; software ignores the rest.
// - Event queue not empty, full and level reached at bit 0 of three words.
// - Transfer-done flag and running flag at bit 0 of their words.
// - Alarm bits 3 to 0 follow alarm outputs of channels four to one.
// - Control bit 11 masks the interrupt output; resets to 0.
// - Control bit 10 picks polarity, 1 active low; resets to 1.
// - Each flag is set by an edge of its condition and cleared by writing 1.
// - Each flag has a mask bit resetting to 1; 1 blocks the flag.
// - Bank summary is the OR of unmasked flags, readable in the summary word.
module iq_status_top
    import iq_pkg::*;
#(
    parameter int NUM_CLAMPS = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [iq_pkg::IQ_AW-1:0] paddr,
    input wire logic [iq_pkg::IQ_DW-1:0] pwdata,
    output logic [iq_pkg::IQ_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic loop_a_lock_flag,
    input wire logic loop_b_reference_lost_flag,
    input wire logic loop_a_reference_lost_flag,
    input wire logic jack_sense_pin_one_b,
    input wire logic jack_sense_pin_two_b,
    input wire logic jack_sense_pin_three_b,
    input wire logic [NUM_CLAMPS-1:0] mic_clamp_enabled,
    input wire logic [NUM_CLAMPS-1:0] mic_clamp_override,
    input wire logic rate_conv_in_a_lock_flag,
    input wire logic rate_conv_in_b_lock_flag,
    input wire logic input_signal_seen_flag,
    input wire logic dyn_range_a_signal_flag,
    input wire logic dyn_range_b_signal_flag,
    input wire logic [7:0] phones_short_flag,
    input wire logic [5:0] phones_on_done,
    input wire logic [5:0] phones_off_done,
    input wire logic [15:0] pin_level,
    input wire logic event_queue_nonempty_flag,
    input wire logic event_queue_full_flag,
    input wire logic event_queue_level_flag,
    input wire logic dsp_transfer_done_flag,
    input wire logic dsp_running_flag,
    input wire logic [3:0] alarm_chan_flag,
    output logic irq_pin_o,
    output logic irq_pin_oe_b
);
    import iq_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_CLAMPS < 1 || NUM_CLAMPS > 8)
    begin : g_bad_clamps
        $error("NUM_CLAMPS must be 1 to 8");
    end

    localparam int SYNC_W = 3 + 3 + 2 * NUM_CLAMPS + 2 + 3 + 8 + 6 + 6 + 16 + 3 + 2 + 4;
    localparam int FLAT_W = IQ_NSLOT * IQ_RW;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] cond_async;
    logic [SYNC_W-1:0] cond_sync;
    logic s_lock_a;
    logic s_ref_b;
    logic s_ref_a;
    logic s_jack1_b;
    logic s_jack2_b;
    logic s_jack3_b;
    logic [NUM_CLAMPS-1:0] s_clamp_en;
    logic [NUM_CLAMPS-1:0] s_clamp_ovd;
    logic s_conv_a;
    logic s_conv_b;
    logic s_input_det;
    logic s_drc_a;
    logic s_drc_b;
    logic [7:0] s_short;
    logic [5:0] s_on;
    logic [5:0] s_off;
    logic [15:0] s_pins;
    logic s_ev_ne;
    logic s_ev_full;
    logic s_ev_lvl;
    logic s_dma;
    logic s_busy;
    logic [3:0] s_alarm;

    // Every condition comes from another domain or a pin
    assign cond_async = {loop_a_lock_flag, loop_b_reference_lost_flag,
        loop_a_reference_lost_flag, jack_sense_pin_one_b, jack_sense_pin_two_b,
        jack_sense_pin_three_b, mic_clamp_enabled, mic_clamp_override,
        rate_conv_in_a_lock_flag, rate_conv_in_b_lock_flag, input_signal_seen_flag,
        dyn_range_a_signal_flag, dyn_range_b_signal_flag, phones_short_flag,
        phones_on_done, phones_off_done, pin_level, event_queue_nonempty_flag,
        event_queue_full_flag, event_queue_level_flag, dsp_transfer_done_flag,
        dsp_running_flag, alarm_chan_flag};

    iq_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_i(cond_async),
        .sync_o(cond_sync)
    );

    // Unpack the synchronised bus
    assign {s_lock_a, s_ref_b, s_ref_a, s_jack1_b, s_jack2_b, s_jack3_b, s_clamp_en,
        s_clamp_ovd, s_conv_a, s_conv_b, s_input_det, s_drc_a, s_drc_b, s_short, s_on,
        s_off, s_pins, s_ev_ne, s_ev_full, s_ev_lvl, s_dma, s_busy, s_alarm} = cond_sync;

    // ------------------------------------------------------------
    // Raw status words
    // ------------------------------------------------------------
    iq_word_t raw_w [IQ_NSLOT];
    logic [FLAT_W-1:0] raw_flat;
    logic clamp_shown;

    // Clamp enabled by its own control, not by override
    assign clamp_shown = |(s_clamp_en & ~s_clamp_ovd);

    // Live words, no latching
    always_comb
    begin
        for (int s = 0; s < IQ_NSLOT; s++)
            raw_w[s] = '0;
        raw_w[IQ_S_CLOCK][IQ_LOOP_A_LOCK_POS] = s_lock_a;
        raw_w[IQ_S_CLOCK][IQ_LOOP_B_REF_POS] = s_ref_b;
        raw_w[IQ_S_CLOCK][IQ_LOOP_A_REF_POS] = s_ref_a;
        raw_w[IQ_S_JACK][IQ_JACK3_POS] = ~s_jack3_b;
        raw_w[IQ_S_JACK][IQ_JACK2_POS] = ~s_jack2_b;
        raw_w[IQ_S_JACK][IQ_JACK1_POS] = ~s_jack1_b;
        raw_w[IQ_S_JACK][IQ_CLAMP_POS] = clamp_shown;
        raw_w[IQ_S_CONV][IQ_CONV_B_POS] = s_conv_b;
        raw_w[IQ_S_CONV][IQ_CONV_A_POS] = s_conv_a;
        raw_w[IQ_S_CONV][IQ_INPUT_DET_POS] = s_input_det;
        raw_w[IQ_S_CONV][IQ_DRC_B_POS] = s_drc_b;
        raw_w[IQ_S_CONV][IQ_DRC_A_POS] = s_drc_a;
        raw_w[IQ_S_SHORT][IQ_SHORT_HI_POS +: 2] = s_short[7:6];
        raw_w[IQ_S_SHORT][5:0] = s_short[5:0];
        raw_w[IQ_S_ON][5:0] = s_on;
        raw_w[IQ_S_OFF][5:0] = s_off;
        raw_w[IQ_S_PINS] = s_pins;
        raw_w[IQ_S_EVNE][0] = s_ev_ne;
        raw_w[IQ_S_EVFULL][0] = s_ev_full;
        raw_w[IQ_S_EVLVL][0] = s_ev_lvl;
        raw_w[IQ_S_DMA][0] = s_dma;
        raw_w[IQ_S_BUSY][0] = s_busy;
        raw_w[IQ_S_ALARM][3:0] = s_alarm;
    end

    // Flatten for the edge logic
    always_comb
    begin
        for (int s = 0; s < IQ_NSLOT; s++)
            raw_flat[s*IQ_RW +: IQ_RW] = raw_w[s];
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic [FLAT_W-1:0] prev_q;
    logic [1:0] prime_q;
    logic primed;
    logic [FLAT_W-1:0] edge_set;

    // History of raw bits, and a short hold-off while the synchroniser fills
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_q <= '0;
            prime_q <= 2'h0;
        end
        else
        begin
            prev_q <= raw_flat;
            prime_q <= primed ? prime_q : prime_q + 2'h1;
        end
    end

    assign primed = (prime_q == 2'h3);

    // Rising edges, both edges for pin levels
    always_comb
    begin
        for (int s = 0; s < IQ_NSLOT; s++)
        begin
            if (s == IQ_S_PINS)
                edge_set[s*IQ_RW +: IQ_RW] = raw_w[s] ^ prev_q[s*IQ_RW +: IQ_RW];
            else
                edge_set[s*IQ_RW +: IQ_RW] = raw_w[s] & ~prev_q[s*IQ_RW +: IQ_RW];
            edge_set[s*IQ_RW +: IQ_RW] = primed ? edge_set[s*IQ_RW +: IQ_RW] : '0;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    iq_idx_t acc_idx;
    iq_slot_t raw_slot;
    iq_slot_t flag_slot;
    iq_slot_t mask_slot;
    logic hit_ctrl;
    logic hit_sum;
    logic mapped;
    logic setup_ph;
    logic wr_acc;
    logic bad_q;

    assign acc_idx = paddr[IQ_AW-1:2];
    assign raw_slot = iq_slot_of(acc_idx, '0);
    assign flag_slot = iq_slot_of(acc_idx, IQ_FLAG_DELTA);
    assign mask_slot = iq_slot_of(acc_idx, IQ_MASK_DELTA);
    assign hit_ctrl = (acc_idx == IQ_CTRL_IDX);
    assign hit_sum = (acc_idx == IQ_SUMMARY_IDX);
    assign mapped = (raw_slot != IQ_NO_SLOT) || (flag_slot != IQ_NO_SLOT)
        || (mask_slot != IQ_NO_SLOT) || hit_ctrl || hit_sum;
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && !bad_q;

    // Zero wait states; error only for an unmapped word
    assign pready = psel && penable;
    assign pslverr = psel && penable && bad_q;

    // ------------------------------------------------------------
    // Control word and flag bank
    // ------------------------------------------------------------
    iq_word_t ctrl_q;
    logic [FLAT_W-1:0] flags;
    logic [FLAT_W-1:0] masks;
    logic [FLAT_W-1:0] clr_flat;
    logic [IQ_NSLOT-1:0] mask_we;
    logic bank_pending;

    // Control bits 11..9; other bits read zero
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_q <= IQ_CTRL_RESET;
        else if (wr_acc && hit_ctrl)
            ctrl_q <= pwdata[IQ_RW-1:0] & IQ_CTRL_BITS;
    end

    // Write one to clear, mask writes; raw words take no write
    always_comb
    begin
        clr_flat = '0;
        mask_we = '0;
        for (int s = 0; s < IQ_NSLOT; s++)
        begin
            if (wr_acc && flag_slot == 4'(s))
                clr_flat[s*IQ_RW +: IQ_RW] = pwdata[IQ_RW-1:0] & IQ_RAW_BITS[s];
            mask_we[s] = wr_acc && (mask_slot == 4'(s));
        end
    end

    iq_flag_bank #(
        .NSLOT(IQ_NSLOT)
    ) u_flags (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .set_i(edge_set),
        .clr_i(clr_flat),
        .mask_we_i(mask_we),
        .wdata_i(pwdata[IQ_RW-1:0]),
        .flags_o(flags),
        .masks_o(masks),
        .pending_o(bank_pending)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    iq_word_t rd_d;
    iq_word_t rd_q;

    // Select the addressed word during the setup cycle
    always_comb
    begin
        rd_d = '0;
        if (raw_slot != IQ_NO_SLOT)
            rd_d = raw_w[raw_slot];
        else if (flag_slot != IQ_NO_SLOT)
            rd_d = flags[flag_slot*IQ_RW +: IQ_RW];
        else if (mask_slot != IQ_NO_SLOT)
            rd_d = masks[mask_slot*IQ_RW +: IQ_RW];
        else if (hit_ctrl)
            rd_d = ctrl_q;
        else if (hit_sum)
            rd_d[IQ_SUM_BANK2_POS] = bank_pending;
    end

    // Data and error captured at setup, shown in the access cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_q <= '0;
            bad_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            rd_q <= pwrite ? '0 : rd_d;
            bad_q <= !mapped;
        end
    end

    assign prdata = {{(IQ_DW - IQ_RW){1'b0}}, rd_q};

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    logic irq_active;
    logic irq_level_q;
    logic irq_oe_b_q;

    // Mask, then polarity; open drain only pulls low
    assign irq_active = bank_pending && !ctrl_q[IQ_CTRL_MASK_POS];

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_level_q <= 1'b1;
            irq_oe_b_q <= 1'b0;
        end
        else
        begin
            irq_level_q <= irq_active ^ ctrl_q[IQ_CTRL_POL_POS];
            irq_oe_b_q <= ctrl_q[IQ_CTRL_ODRAIN_POS] && (irq_active ^ ctrl_q[IQ_CTRL_POL_POS]);
        end
    end

    assign irq_pin_o = irq_level_q;
    assign irq_pin_oe_b = irq_oe_b_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_jack_active_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!jack_sense_pin_three_b)[*3] |-> raw_w[IQ_S_JACK][IQ_JACK3_POS])
        else $error("jack three low but not reported present");
    a_clamp_no_override: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mic_clamp_enabled == mic_clamp_override)[*3] |-> !raw_w[IQ_S_JACK][IQ_CLAMP_POS])
        else $error("clamp shown though enabled only by override");
    a_summary_or: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hit_sum && setup_ph && !pwrite |=> rd_q[IQ_SUM_BANK2_POS] == $past(|(flags & ~masks)))
        else $error("summary differs from unmasked flags");
    a_irq_mask_blocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctrl_q[IQ_CTRL_MASK_POS] |=> (irq_level_q == $past(ctrl_q[IQ_CTRL_POL_POS])))
        else $error("masked output still asserted");
    a_irq_polarity: assert property (@(posedge clk_sys) disable iff (!rst_b)
        bank_pending && !ctrl_q[IQ_CTRL_MASK_POS] |=> irq_level_q != $past(ctrl_q[10]))
        else $error("pending interrupt shown at wrong polarity");
    a_ctrl_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(rst_b) |-> (ctrl_q == IQ_CTRL_RESET && irq_level_q))
        else $error("control word or output wrong after reset");
    a_raw_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_acc && raw_slot != IQ_NO_SLOT) |=> $stable(ctrl_q) && $stable(masks))
        else $error("write to raw word changed state");
endmodule : iq_status_top

// ---- sim/iq_host_model.sv ----
// Purpose: Host end of the interrupt line, with the board pull-up.
// Assumes: The line floats high whenever the block releases it.
// Notes:   Polarity is decoded by whoever reads irq_line.
module iq_host_model (
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe_b,
    output logic irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins while the pin is released
    assign irq_line = irq_pin_oe_b ? 1'b1 : irq_pin_o;
endmodule : iq_host_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the bank two status and interrupt block.
// Assumes: Conditions reach the raw words within four clocks.
// Notes:   One condition vector c feeds every status input.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iq_pkg::*;
    typedef struct {int pos; logic [15:0] val; iq_idx_t idx; iq_word_t exp;} iq_row_t;
    logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic irq_pin_o, irq_pin_oe_b, irq_line;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] c;
    int fails, n_compared;
    // ------------------------------------------------------------
    // Raw word table: flipped condition bits and expected word
    // ------------------------------------------------------------
    iq_row_t rows [22] = '{
        '{0, 16'h0001, 14'h1981, 16'h0100}, '{1, 16'h0003, 14'h1981, 16'h0060},
        '{3, 16'h0001, 14'h1986, 16'h0001}, '{4, 16'h0001, 14'h1986, 16'h0004},
        '{5, 16'h0001, 14'h1986, 16'h0100}, '{6, 16'h0008, 14'h1986, 16'h0010},
        '{6, 16'h0011, 14'h1986, 16'h0000}, '{6, 16'h0021, 14'h1986, 16'h0010},
        '{14, 16'h0001, 14'h1988, 16'h0100}, '{14, 16'h0002, 14'h1988, 16'h0200},
        '{16, 16'h0005, 14'h1988, 16'h0006}, '{17, 16'h0001, 14'h1988, 16'h0001},
        '{19, 16'h00c1, 14'h198b, 16'h0301}, '{27, 16'h002a, 14'h198c, 16'h002a},
        '{33, 16'h0015, 14'h198d, 16'h0015}, '{39, 16'ha5c3, 14'h1990, 16'ha5c3},
        '{56, 16'h0001, 14'h1996, 16'h0001}, '{58, 16'h0001, 14'h1998, 16'h0001},
        '{55, 16'h0001, 14'h1995, 16'h0001}, '{57, 16'h0001, 14'h1997, 16'h0001},
        '{59, 16'h0001, 14'h199d, 16'h0001},
        '{60, 16'h0009, 14'h19a3, 16'h0009}};
    iq_status_top #(.NUM_CLAMPS(4)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_a_lock_flag(c[0]), .loop_b_reference_lost_flag(c[1]),
        .loop_a_reference_lost_flag(c[2]), .jack_sense_pin_one_b(c[3]),
        .jack_sense_pin_two_b(c[4]), .jack_sense_pin_three_b(c[5]),
        .mic_clamp_enabled(c[9:6]), .mic_clamp_override(c[13:10]),
        .rate_conv_in_a_lock_flag(c[14]), .rate_conv_in_b_lock_flag(c[15]),
        .input_signal_seen_flag(c[16]), .dyn_range_a_signal_flag(c[17]),
        .dyn_range_b_signal_flag(c[18]), .phones_short_flag(c[26:19]),
        .phones_on_done(c[32:27]), .phones_off_done(c[38:33]), .pin_level(c[54:39]),
        .event_queue_nonempty_flag(c[55]), .event_queue_full_flag(c[56]),
        .event_queue_level_flag(c[57]), .dsp_transfer_done_flag(c[58]),
        .dsp_running_flag(c[59]), .alarm_chan_flag(c[63:60]), .irq_pin_o(irq_pin_o),
        .irq_pin_oe_b(irq_pin_oe_b));
    iq_host_model host (.irq_pin_o(irq_pin_o), .irq_pin_oe_b(irq_pin_oe_b), .irq_line(irq_line));
    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Cut a hang short well past the expected run length
    initial
    begin
        #80000;
        fails++;
        stop_test();
    end
    task automatic stop_test();
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input iq_idx_t idx, input iq_word_t wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1); // Only the watchdog ends a stalled wait
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rdc(input iq_idx_t idx, input iq_word_t e);
        apb(1'b0, idx, 16'h0000);
        chk("read word", {16'h0000, e}, rd);
    endtask : rdc
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        c = 64'h38;
        rst_b = 1'b0;
        repeat (16) @(posedge clk_sys);
        chk("irq pin", 1'b1, irq_pin_o);
        rst_b <= 1'b1;
        rdc(14'h1a80, 16'h0400);
        rdc(14'h1963, 16'hffff);
        foreach (rows[i])
        begin
            c <= 64'h38 ^ (64'(rows[i].val) << rows[i].pos);
            repeat (4) @(posedge clk_sys);
            rdc(rows[i].idx, rows[i].exp);
        end
        c <= 64'h38;
        repeat (4) @(posedge clk_sys);
        apb(1'b1, 14'h19a3, 16'hffff);
        rdc(14'h19a3, 16'h0000);
        rdc(14'h1923, 16'h0009);
        apb(1'b1, 14'h1923, 16'h0001);
        rdc(14'h1923, 16'h0008);
        rdc(14'h1aa0, 16'h0000);
        apb(1'b1, 14'h1963, 16'hfff7);
        rdc(14'h1aa0, 16'h0002);
        repeat (2) @(posedge clk_sys);
        chk("irq pin", 1'b0, irq_pin_o);
        apb(1'b1, 14'h1a80, 16'h0c00);
        repeat (2) @(posedge clk_sys);
        chk("irq pin", 1'b1, irq_pin_o);
        apb(1'b1, 14'h1a80, 16'h0200);
        repeat (2) @(posedge clk_sys);
        chk("irq line", 1'b1, irq_line);
        apb(1'b1, 14'h1923, 16'h0008);
        rdc(14'h1aa0, 16'h0000);
        repeat (2) @(posedge clk_sys);
        chk("irq line", 1'b0, irq_line);
        apb(1'b0, 14'h1a81, 16'h0000);
        chk("slave error", 1'b1, err);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(14'h1a80, 16'h0400);
        stop_test();
    end
endmodule : tb_top
